//--- hw/ccs_clock_ctrl.sv
/*
 * CPU clock source mode control: picks the CPU clock source and gates the
 * idle oscillators from software flags.
 * Assumes all flag inputs come from registers clocked by clk_sys_i.
 */
`timescale 1ns/1ps

// Operation
// R1: HS mode: status 0/1, internal stop honoured
// R2: Internal mode: status 0/0, hs_osc_stop honoured
// R3: Subsystem mode: status 1/1, subsystem stop honoured
// R4: Internal stop needs option strap permission
// R5: HS mode keeps high-speed oscillator running
// R6: Internal mode ignores subsystem stop flag
// R7: Subsystem entry only from high-speed mode
// R8: Subsystem exit only to high-speed mode
// R9: No main-select clear in subsystem mode
// R10: Subsystem mode ignores hs_osc_stop
// R11: Source switches after delay; status shows actual
// R12: Illegal requests keep current source
module ccs_clock_ctrl (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       subsys_hs_osc_stop_i,
	input  wire logic       subsystem_select_i,
	input  wire logic       main_source_select_i,
	input  wire logic       hs_osc_stop_i,
	input  wire logic       internal_osc_stop_i,
	input  wire logic       internal_osc_stoppable_i,
	output logic            subsystem_active_status_o,
	output logic            hs_active_status_o,
	output logic [1:0]      cpu_source_o,
	output logic            hs_osc_run_o,
	output logic            internal_osc_run_o
);

	ccs_pkg::ccs_mode_e mode_ff;
	ccs_pkg::ccs_mode_e pend_tgt_ff;
	ccs_pkg::ccs_mode_e req_tgt;
	logic               pend_ff;
	logic               req_valid;
	logic               hs_run_ff;
	logic               int_run_ff;
	logic               nxt_hs_run;
	logic               nxt_int_run;
	logic               sub_st_ff;
	logic               hs_st_ff;

	ccs_sw_if sw ();

	// ----------------------------------------------------------------
	// Switch delay timer
	// ----------------------------------------------------------------
	ccs_switch_timer u_timer (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.sw        (sw.timer)
	);

	// ----------------------------------------------------------------
	// Requested source from the select flags
	// ----------------------------------------------------------------
	// Only legal moves are requested; anything else holds the mode
	always_comb begin
		req_valid = 1'b0;
		req_tgt   = mode_ff;
		case (mode_ff)
			ccs_pkg::CCS_MODE_IOSC: begin
				if (!subsystem_select_i && main_source_select_i) begin
					req_valid = 1'b1;
					req_tgt   = ccs_pkg::CCS_MODE_HS;
				end // Subsystem select here is refused [R7] [R12]
			end
			ccs_pkg::CCS_MODE_HS: begin
				if (!subsystem_select_i && !main_source_select_i) begin
					req_valid = 1'b1;
					req_tgt   = ccs_pkg::CCS_MODE_IOSC;
				end else if (subsystem_select_i && main_source_select_i) begin
					req_valid = 1'b1;
					req_tgt   = ccs_pkg::CCS_MODE_SUB; // [R7]
				end
			end
			ccs_pkg::CCS_MODE_SUB: begin
				if (!subsystem_select_i && main_source_select_i) begin
					req_valid = 1'b1;
					req_tgt   = ccs_pkg::CCS_MODE_HS; // [R8]
				end // Main-select clear is refused [R9] [R12]
			end
			default: begin
				req_valid = 1'b0;
			end
		endcase
	end

	// Start a delay on a new request, drop it if the request changes
	assign sw.start = !pend_ff && req_valid;
	assign sw.abort = pend_ff && (!req_valid || (req_tgt != pend_tgt_ff));

	// ----------------------------------------------------------------
	// Pending switch and active mode
	// ----------------------------------------------------------------
	// Mode moves only when the delay completes [R11]
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mode_ff     <= ccs_pkg::MODE_RST;
			pend_tgt_ff <= ccs_pkg::MODE_RST;
			pend_ff     <= 1'b0;
			sub_st_ff   <= ccs_pkg::SUB_ST_RST;
			hs_st_ff    <= ccs_pkg::HS_ST_RST;
		end else begin
			if (sw.abort) begin
				pend_ff <= 1'b0; // [R12]
			end else if (sw.start) begin
				pend_ff     <= 1'b1;
				pend_tgt_ff <= req_tgt;
			end else if (pend_ff && sw.done) begin
				pend_ff   <= 1'b0;
				mode_ff   <= pend_tgt_ff; // [R11]
				sub_st_ff <= (pend_tgt_ff == ccs_pkg::CCS_MODE_SUB); // Status moves with the source [R11]
				hs_st_ff  <= (pend_tgt_ff != ccs_pkg::CCS_MODE_IOSC);
			end
		end
	end

	// ----------------------------------------------------------------
	// Oscillator gating
	// ----------------------------------------------------------------
	// Stop flags honoured per mode; in-use or target oscillator kept on
	always_comb begin
		nxt_hs_run  = 1'b1;
		nxt_int_run = !(internal_osc_stoppable_i && internal_osc_stop_i); // [R4]
		case (mode_ff)
			ccs_pkg::CCS_MODE_HS: begin
				nxt_hs_run = 1'b1; // HS stop flags ignored [R5] [R1]
			end
			ccs_pkg::CCS_MODE_IOSC: begin
				nxt_hs_run  = !hs_osc_stop_i; // Subsystem stop ignored [R6] [R2]
				nxt_int_run = 1'b1;
			end
			ccs_pkg::CCS_MODE_SUB: begin
				nxt_hs_run = !subsys_hs_osc_stop_i; // hs_osc_stop ignored [R10] [R3]
			end
			default: begin
				nxt_hs_run = 1'b1;
			end
		endcase
		if (pend_ff && (pend_tgt_ff == ccs_pkg::CCS_MODE_HS)) begin
			nxt_hs_run = 1'b1; // [R12]
		end
		if (pend_ff && (pend_tgt_ff == ccs_pkg::CCS_MODE_IOSC)) begin
			nxt_int_run = 1'b1; // [R12]
		end
	end

	// Register oscillator enables
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			hs_run_ff  <= ccs_pkg::HS_RUN_RST;
			int_run_ff <= ccs_pkg::INT_RUN_RST;
		end else begin
			hs_run_ff  <= nxt_hs_run;
			int_run_ff <= nxt_int_run;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Status reflects the source actually in use [R11]
	assign subsystem_active_status_o = sub_st_ff;
	assign hs_active_status_o        = hs_st_ff;
	assign cpu_source_o              = mode_ff;
	assign hs_osc_run_o              = hs_run_ff;
	assign internal_osc_run_o        = int_run_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hs_status;
		@(posedge clk_sys_i) disable iff (rst_i)
		(cpu_source_o == 2'(ccs_pkg::CCS_MODE_HS)) |-> (!subsystem_active_status_o && hs_active_status_o);
	endproperty
	a_hs_status: assert property (p_hs_status) else $error("HS mode status wrong"); // [R1]

	property p_iosc_status;
		@(posedge clk_sys_i) disable iff (rst_i)
		(cpu_source_o == 2'(ccs_pkg::CCS_MODE_IOSC)) |-> !(subsystem_active_status_o || hs_active_status_o);
	endproperty
	a_iosc_status: assert property (p_iosc_status) else $error("Internal mode status wrong"); // [R2]

	property p_sub_status;
		@(posedge clk_sys_i) disable iff (rst_i)
		(cpu_source_o == 2'(ccs_pkg::CCS_MODE_SUB)) |-> (subsystem_active_status_o && hs_active_status_o);
	endproperty
	a_sub_status: assert property (p_sub_status) else $error("Subsystem mode status wrong"); // [R3]

	property p_strap_keeps_int;
		@(posedge clk_sys_i) disable iff (rst_i)
		!internal_osc_stoppable_i |=> internal_osc_run_o;
	endproperty
	a_strap_keeps_int: assert property (p_strap_keeps_int) else $error("Internal osc stopped without permission"); // [R4]

	property p_hs_keeps_hs;
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == ccs_pkg::CCS_MODE_HS) |=> hs_osc_run_o;
	endproperty
	a_hs_keeps_hs: assert property (p_hs_keeps_hs) else $error("HS osc stopped in HS mode"); // [R5]

	property p_iosc_ignores_sub_stop;
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == ccs_pkg::CCS_MODE_IOSC) && !hs_osc_stop_i |=> hs_osc_run_o;
	endproperty
	a_iosc_ignores_sub_stop: assert property (p_iosc_ignores_sub_stop) else $error("Subsystem stop acted in internal mode"); // [R6]

	property p_sub_ignores_hs_osc_stop;
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == ccs_pkg::CCS_MODE_SUB) && !subsys_hs_osc_stop_i |=> hs_osc_run_o;
	endproperty
	a_sub_ignores_hs_osc_stop: assert property (p_sub_ignores_hs_osc_stop) else $error("hs_osc_stop acted in subsystem mode"); // [R10]

	property p_no_iosc_to_sub;
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == ccs_pkg::CCS_MODE_IOSC) |=> (mode_ff != ccs_pkg::CCS_MODE_SUB);
	endproperty
	a_no_iosc_to_sub: assert property (p_no_iosc_to_sub) else $error("Direct internal to subsystem switch"); // [R7]

	property p_sub_exit_hs;
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == ccs_pkg::CCS_MODE_SUB) |=> (mode_ff != ccs_pkg::CCS_MODE_IOSC);
	endproperty
	a_sub_exit_hs: assert property (p_sub_exit_hs) else $error("Subsystem exit not to HS"); // [R8]

	property p_switch_after_delay;
		@(posedge clk_sys_i) disable iff (rst_i)
		$changed(cpu_source_o) |-> $past(pend_ff, 1) && $past(pend_ff, 2) && $past(sw.start, 3);
	endproperty
	a_switch_after_delay: assert property (p_switch_after_delay) else $error("Source switched without delay"); // [R11]

	property p_illegal_holds;
		@(posedge clk_sys_i) disable iff (rst_i)
		!req_valid && !pend_ff |=> $stable(cpu_source_o);
	endproperty
	a_illegal_holds: assert property (p_illegal_holds) else $error("Source changed without legal request"); // [R12]

endmodule // ccs_clock_ctrl

//--- hw/ccs_pkg.sv
/*
 * Shared constants and types for the CPU clock source mode control block.
 * Assumes a single system clock and an asynchronous active-high reset.
 */
package ccs_pkg;

	// ----------------------------------------------------------------
	// CPU clock source modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CCS_MODE_IOSC,
		CCS_MODE_HS,
		CCS_MODE_SUB
	} ccs_mode_e;

	// ----------------------------------------------------------------
	// Reset values and switch timing
	// ----------------------------------------------------------------
	localparam ccs_mode_e   MODE_RST      = CCS_MODE_IOSC; // Start on internal oscillator
	localparam logic        HS_RUN_RST    = 1'b1;          // Stop flags reset to 0
	localparam logic        INT_RUN_RST   = 1'b1;
	localparam int          CNT_W         = 2;
	localparam logic [1:0]  SWITCH_CLOCKS = 2'h2;          // Clocks on old source before switch
	localparam logic [1:0]  CNT_RST       = 2'h0;
	localparam logic        SUB_ST_RST    = 1'b0;          // Status flags match MODE_RST
	localparam logic        HS_ST_RST     = 1'b0;

endpackage

//--- hw/ccs_sw_if.sv
/*
 * Handshake between the mode controller and the switch delay timer.
 * Assumes both ends share clk_sys_i.
 */
`timescale 1ns/1ps

interface ccs_sw_if;
	logic start;  // Begin a switch delay
	logic abort;  // Drop a pending switch
	logic done;   // Delay elapsed, one-cycle pulse

	modport ctrl  (output start, output abort, input done);
	modport timer (input start, input abort, output done);
endinterface

//--- hw/ccs_switch_timer.sv
/*
 * Switch delay timer: pulses done a fixed number of clocks after start.
 * Assumes start is raised only while idle; abort cancels at once.
 */
`timescale 1ns/1ps

module ccs_switch_timer (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	ccs_sw_if.timer   sw
);

	logic                     busy_ff;
	logic [ccs_pkg::CNT_W-1:0] cnt_ff;
	logic                     done_ff;

	// ----------------------------------------------------------------
	// Countdown
	// ----------------------------------------------------------------
	// Load on start, count down while busy, pulse done at one
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
			cnt_ff  <= ccs_pkg::CNT_RST;
			done_ff <= 1'b0;
		end else begin
			done_ff <= busy_ff && !sw.abort && (cnt_ff == 2'h1); // [R11]
			if (sw.abort) begin
				busy_ff <= 1'b0;
			end else if (sw.start) begin
				busy_ff <= 1'b1;
				cnt_ff  <= ccs_pkg::SWITCH_CLOCKS - 2'h1;
			end else if (busy_ff) begin
				cnt_ff  <= cnt_ff - 2'h1;
				busy_ff <= (cnt_ff != 2'h1);
			end
		end
	end

	assign sw.done = done_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_delay_exact;
		@(posedge clk_sys_i) disable iff (rst_i)
		(sw.start && !sw.abort) ##1 !sw.abort |=> sw.done;
	endproperty
	a_delay_exact: assert property (p_delay_exact) else $error("Switch delay not two clocks"); // [R11]

	property p_no_early_done;
		@(posedge clk_sys_i) disable iff (rst_i)
		sw.start |=> !sw.done;
	endproperty
	a_no_early_done: assert property (p_no_early_done) else $error("Switch done too early"); // [R11]

endmodule // ccs_switch_timer

//--- verif/ccs_clock_ctrl_tb.sv
/*
 * Self-checking bench for the CPU clock source mode control block.
 * Assumes the design's own assertions guard cycle timing; this bench drives flags on falling edges.
 */
`timescale 1ns/1ps

module tb;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic       clk_sys_i;
	logic       rst_i;
	logic       subsys_hs_osc_stop_i;
	logic       subsystem_select_i;
	logic       main_source_select_i;
	logic       hs_osc_stop_i;
	logic       internal_osc_stop_i;
	logic       internal_osc_stoppable_i;
	logic       subsystem_active_status_o;
	logic       hs_active_status_o;
	logic [1:0] cpu_source_o;
	logic       hs_osc_run_o;
	logic       internal_osc_run_o;
	int         num_errors;
	int         n_checks;

	ccs_clock_ctrl dut (
		.clk_sys_i                 (clk_sys_i),
		.rst_i                     (rst_i),
		.subsys_hs_osc_stop_i      (subsys_hs_osc_stop_i),
		.subsystem_select_i        (subsystem_select_i),
		.main_source_select_i      (main_source_select_i),
		.hs_osc_stop_i             (hs_osc_stop_i),
		.internal_osc_stop_i       (internal_osc_stop_i),
		.internal_osc_stoppable_i  (internal_osc_stoppable_i),
		.subsystem_active_status_o (subsystem_active_status_o),
		.hs_active_status_o        (hs_active_status_o),
		.cpu_source_o              (cpu_source_o),
		.hs_osc_run_o              (hs_osc_run_o),
		.internal_osc_run_o        (internal_osc_run_o)
	);

	// 100 MHz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Flags in order: sub stop, select, main, hs stop, int stop, strap
	task automatic set_flags(input logic [5:0] f);
		@(negedge clk_sys_i);
		{subsys_hs_osc_stop_i, subsystem_select_i, main_source_select_i,
			hs_osc_stop_i, internal_osc_stop_i, internal_osc_stoppable_i} = f;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// Bounded wait for the source to reach a value
	task automatic wait_src(input logic [1:0] exp);
		int i;
		for (i = 0; i < 8; i++) begin
			@(negedge clk_sys_i);
			if (cpu_source_o === exp) break;
		end
		if (i == 8) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, cpu_source_o, exp);
			end_of_test();
		end
	endtask

	// Status pair and oscillator enables together
	task automatic chk_state(input logic [1:0] src, input logic [1:0] st, input logic [1:0] run);
		chk({2'h0, cpu_source_o}, {2'h0, src});
		chk({2'h0, subsystem_active_status_o, hs_active_status_o}, {2'h0, st});
		chk({2'h0, hs_osc_run_o, internal_osc_run_o}, {2'h0, run});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_int_mode();
		set_flags(6'b100000);
		settle(4);
		chk_state(2'h0, 2'h0, 2'h3);
		set_flags(6'b000101);
		settle(4);
		chk_state(2'h0, 2'h0, 2'h1);
		set_flags(6'b000011);
		settle(4);
		chk({3'h0, internal_osc_run_o}, 4'h1);
		set_flags(6'b110000);
		settle(8);
		chk_state(2'h0, 2'h0, 2'h3);
		set_flags(6'b011000);
		settle(8);
		chk({2'h0, cpu_source_o}, 4'h0);
		// Request withdrawn inside the switch delay
		set_flags(6'b001000);
		set_flags(6'b000000);
		settle(4);
		chk_state(2'h0, 2'h0, 2'h3);
	endtask

	task automatic t_to_hs();
		set_flags(6'b001000);
		settle(1);
		chk({2'h0, cpu_source_o}, 4'h0);
		wait_src(2'h1);
		settle(2);
		chk_state(2'h1, 2'h1, 2'h3);
		set_flags(6'b101111);
		settle(4);
		chk_state(2'h1, 2'h1, 2'h2);
		set_flags(6'b101110);
		settle(4);
		chk_state(2'h1, 2'h1, 2'h3);
		set_flags(6'b010000);
		settle(8);
		chk({2'h0, cpu_source_o}, 4'h1);
	endtask

	task automatic t_to_sub();
		set_flags(6'b011000);
		wait_src(2'h2);
		settle(2);
		chk_state(2'h2, 2'h3, 2'h3);
		set_flags(6'b011101);
		settle(4);
		chk({3'h0, hs_osc_run_o}, 4'h1);
		set_flags(6'b111011);
		settle(4);
		chk_state(2'h2, 2'h3, 2'h0);
		set_flags(6'b010000);
		settle(8);
		chk_state(2'h2, 2'h3, 2'h3);
		set_flags(6'b000000);
		settle(8);
		chk({2'h0, cpu_source_o}, 4'h2);
	endtask

	task automatic t_back();
		set_flags(6'b001000);
		wait_src(2'h1);
		settle(2);
		chk_state(2'h1, 2'h1, 2'h3);
		set_flags(6'b000000);
		wait_src(2'h0);
		settle(2);
		chk_state(2'h0, 2'h0, 2'h3);
	endtask

	// Reset in mid-run from high-speed mode
	task automatic t_reset();
		set_flags(6'b001000);
		wait_src(2'h1);
		rst_i = 1'b1;
		set_flags(6'b000000);
		settle(2);
		chk_state(2'h0, 2'h0, 2'h3); // Reset values
		rst_i = 1'b0;
		settle(2);
		chk_state(2'h0, 2'h0, 2'h3);
		set_flags(6'b001000);
		wait_src(2'h1);
		settle(2);
		chk_state(2'h1, 2'h1, 2'h3);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		num_errors = 0;
		n_checks   = 0;
		rst_i      = 1'b1;
		{subsys_hs_osc_stop_i, subsystem_select_i, main_source_select_i,
			hs_osc_stop_i, internal_osc_stop_i, internal_osc_stoppable_i} = 6'h00;
		settle(5);
		chk_state(2'h0, 2'h0, 2'h3); // Reset values
		rst_i = 1'b0;
		settle(2);
		t_int_mode();
		t_to_hs();
		t_to_sub();
		t_back();
		t_reset();
		end_of_test();
	end

endmodule // tb
